// file: src/acs_pkg.sv
// Constants, frame layout and carriers for the ADC channel sequencer.
// Assumes a 16-clock serial frame: addr[15:9], write flag[8], data[7:0].
package acs_pkg;

  // ***********************************
  // Frame and register map
  // ***********************************
  localparam int        FRAME_BITS   = 16;
  localparam int        SCLK_NS      = 160;
  localparam int        SYS_CLK_NS   = 50;
  localparam logic [6:0] ADDR_SWRST  = 7'h01;
  localparam logic [6:0] ADDR_MANUAL = 7'h04;
  localparam logic [6:0] ADDR_AUTO   = 7'h05;
  localparam logic [6:0] ADDR_AUX    = 7'h06;
  localparam logic [6:0] ADDR_MASK   = 7'h0C;
  localparam logic [6:0] ADDR_PAGE   = 7'h7F;

  // ***********************************
  // Field positions and codes
  // ***********************************
  localparam int         CH_LO       = 5;
  localparam int         RNG_LO      = 1;
  localparam int         TEMP_BIT    = 0;
  localparam int         SEQ_RST_BIT = 7;
  localparam int         PINFN_BIT   = 3;
  localparam int         REF_BIT     = 2;
  localparam int         TSEN_BIT    = 1;
  localparam int         SWRST_BIT   = 0;
  localparam int         PAGE_BIT    = 0;
  localparam int         INC_CH0_BIT = 7;
  localparam logic [2:0] RANGE_CFG   = 3'h0;
  localparam logic [2:0] RANGE_PD    = 3'h7;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [1:0] CH_ZERO     = 2'h0;

  typedef enum logic {
    ACS_MODE_MANUAL = 1'b0,
    ACS_MODE_AUTO   = 1'b1
  } acs_mode_e;

  typedef struct packed {
    logic [6:0] addr;
    logic       wr;
    logic [7:0] data;
  } acs_frame_s;

  typedef struct packed {
    logic       temp;
    logic [1:0] ch;
    logic [2:0] range;
  } acs_acq_s;

endpackage : acs_pkg

// file: src/acs_sequencer.sv
// Channel sequencing and configuration control of a four-channel ADC.
// Assumes a 16-clock serial master, din on sclk rise, async to sys_clk.
`timescale 1ns/1ns

module acs_sequencer
  import acs_pkg::*;
(
  // System
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  // Serial link
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       din_i,
  // Shared alarm / sleep pin
  input  wire logic       alarm_or_sleep_pin_i,
  output logic            alarm_or_sleep_pin_o,
  output logic            alarm_or_sleep_pin_oe_o,
  input  wire logic       alarm_i,
  // Acquisition control
  output acs_acq_s        acq_o,
  output acs_acq_s        result_o,
  output logic            frame_o,
  output logic            auto_mode_o,
  output logic            power_down_o,
  output logic            dev_reset_o,
  // Auxiliary blocks
  output logic            ref_en_o,
  output logic            temp_en_o,
  output logic            shared_pin_function_o,
  output logic            page_o,
  output logic [7:0]      channel_mask_o
);

  // ***********************************
  // Link domain: frame shifter
  // ***********************************
  logic [3:0]  bit_cnt_r;
  logic [14:0] shift_r;
  acs_frame_s  word_r;
  logic        tog_r;

  // Counter restarts whenever the frame strobe goes away
  always_ff @(posedge sclk_i or posedge cs_n_i or negedge resetn_i) begin
    if (!resetn_i || cs_n_i) begin
      bit_cnt_r <= '0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shift_r <= '0;
    end else if (!cs_n_i) begin
      shift_r <= {shift_r[13:0], din_i};
    end
  end

  // Word stays stable for a whole frame, far longer than the sync path
  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      word_r <= '0;
      tog_r  <= 1'b0;
    end else if (!cs_n_i && bit_cnt_r == 4'(FRAME_BITS - 1)) begin
      word_r <= {shift_r, din_i};
      tog_r  <= ~tog_r;
    end
  end

  // ***********************************
  // Crossings into the system domain
  // ***********************************
  logic [2:0] tog_s, pin_s;
  logic       sleep_lvl_r;
  logic       ev_r;
  acs_frame_s cmd_r;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tog_s <= '0;
      pin_s <= '0;
    end else begin
      tog_s <= {tog_s[1:0], tog_r};
      pin_s <= {pin_s[1:0], alarm_or_sleep_pin_i};
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sleep_lvl_r <= 1'b0;
    end else if (pin_s[1] == pin_s[2]) begin
      sleep_lvl_r <= pin_s[2];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ev_r  <= 1'b0;
      cmd_r <= '0;
    end else begin
      ev_r <= tog_s[1] ^ tog_s[2];
      if (tog_s[1] ^ tog_s[2]) begin
        cmd_r <= word_r;
      end
    end
  end

  // ***********************************
  // Next acquisition
  // ***********************************
  acs_mode_e  mode_r, mode_nxt;
  logic [1:0] man_ch_r, man_ch_nxt;
  logic       temp_r, temp_nxt;
  logic [1:0] seq_r;
  logic [2:0] ovr_nxt;
  logic       rst_seq_nxt;
  logic       wr_p0;
  logic       swrst_nxt;
  logic [7:0] mask_r;
  logic [7:0] aux_r;
  acs_acq_s   acq_nxt;

  // Lowest selected channel above cur, else wrap to the lowest one
  function automatic logic [1:0] acs_next_ch(input logic [7:0] m,
                                             input logic [1:0] cur,
                                             input logic       restart);
    logic [1:0] lo, hi;
    logic       found;
    lo    = CH_ZERO;
    hi    = CH_ZERO;
    found = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      if (m[INC_CH0_BIT - 2 * i]) begin
        lo = 2'(i);
        if (2'(i) > cur) begin
          hi    = 2'(i);
          found = 1'b1;
        end
      end
    end
    return (restart || !found) ? lo : hi;
  endfunction : acs_next_ch

  always_comb begin
    wr_p0       = cmd_r.wr && !page_o;
    mode_nxt    = mode_r;
    man_ch_nxt  = man_ch_r;
    temp_nxt    = temp_r;
    ovr_nxt     = RANGE_CFG;
    rst_seq_nxt = 1'b0;
    swrst_nxt   = wr_p0 && cmd_r.addr == ADDR_SWRST && cmd_r.data[SWRST_BIT];
    if (wr_p0 && cmd_r.addr == ADDR_MANUAL) begin
      mode_nxt   = ACS_MODE_MANUAL;
      man_ch_nxt = cmd_r.data[CH_LO +: 2];
      ovr_nxt    = cmd_r.data[RNG_LO +: 3];
      temp_nxt   = cmd_r.data[TEMP_BIT];
    end else if (wr_p0 && cmd_r.addr == ADDR_AUTO) begin
      mode_nxt    = ACS_MODE_AUTO;
      ovr_nxt     = cmd_r.data[RNG_LO +: 3];
      temp_nxt    = cmd_r.data[TEMP_BIT];
      rst_seq_nxt = cmd_r.data[SEQ_RST_BIT];
    end
    acq_nxt.temp  = temp_nxt;
    acq_nxt.range = (temp_nxt || ovr_nxt == RANGE_PD)
                    ? RANGE_CFG : ovr_nxt;
    case (mode_nxt)
      ACS_MODE_MANUAL: acq_nxt.ch = man_ch_nxt;
      ACS_MODE_AUTO: begin
        if (temp_nxt) begin
          acq_nxt.ch = seq_r;
        end else begin
          acq_nxt.ch = acs_next_ch(mask_r, seq_r, rst_seq_nxt);
        end
      end
      default: acq_nxt.ch = CH_ZERO;
    endcase
  end

  // ***********************************
  // Frame-boundary state
  // ***********************************
  // Sequence pointer holds the channel of the last auto conversion
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r   <= ACS_MODE_MANUAL;
      man_ch_r <= CH_ZERO;
      temp_r   <= 1'b0;
      seq_r    <= CH_ZERO;
      acq_o    <= '0;
      result_o <= '0;
    end else if (ev_r && swrst_nxt) begin
      mode_r   <= ACS_MODE_MANUAL;
      man_ch_r <= CH_ZERO;
      temp_r   <= 1'b0;
      seq_r    <= CH_ZERO;
      acq_o    <= '0;
      result_o <= acq_o;
    end else if (ev_r) begin
      mode_r   <= mode_nxt;
      man_ch_r <= man_ch_nxt;
      temp_r   <= temp_nxt;
      acq_o    <= acq_nxt;
      result_o <= acq_o;
      if (mode_nxt == ACS_MODE_AUTO && !temp_nxt) begin
        seq_r <= acq_nxt.ch;
      end
    end
  end

  // Page select is reachable from either page
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      page_o <= 1'b0;
    end else if (ev_r && swrst_nxt) begin
      page_o <= 1'b0;
    end else if (ev_r && cmd_r.wr && cmd_r.addr == ADDR_PAGE) begin
      page_o <= cmd_r.data[PAGE_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aux_r  <= REG_RESET;
      mask_r <= REG_RESET;
    end else if (ev_r && swrst_nxt) begin
      aux_r  <= REG_RESET;
      mask_r <= REG_RESET;
    end else if (ev_r && wr_p0) begin
      if (cmd_r.addr == ADDR_AUX) begin
        aux_r <= cmd_r.data;
      end
      if (cmd_r.addr == ADDR_MASK) begin
        mask_r <= cmd_r.data;
      end
    end
  end

  // ***********************************
  // Outputs
  // ***********************************
  logic pd_cmd_r;

  // Power-down by range code lasts until the next frame arrives
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pd_cmd_r    <= 1'b0;
      dev_reset_o <= 1'b0;
      frame_o     <= 1'b0;
    end else begin
      frame_o     <= ev_r;
      dev_reset_o <= ev_r && swrst_nxt;
      if (ev_r) begin
        pd_cmd_r <= !swrst_nxt && ovr_nxt == RANGE_PD;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      power_down_o            <= 1'b0;
      auto_mode_o             <= 1'b0;
      ref_en_o                <= 1'b0;
      temp_en_o               <= 1'b0;
      shared_pin_function_o   <= 1'b0;
      channel_mask_o          <= REG_RESET;
      alarm_or_sleep_pin_o    <= 1'b0;
      alarm_or_sleep_pin_oe_o <= 1'b0;
    end else begin
      power_down_o <= pd_cmd_r || (aux_r[PINFN_BIT] && sleep_lvl_r);
      auto_mode_o             <= mode_r == ACS_MODE_AUTO;
      ref_en_o                <= aux_r[REF_BIT];
      temp_en_o               <= aux_r[TSEN_BIT];
      shared_pin_function_o   <= aux_r[PINFN_BIT];
      channel_mask_o          <= mask_r;
      alarm_or_sleep_pin_o    <= alarm_i;
      alarm_or_sleep_pin_oe_o <= !aux_r[PINFN_BIT];
    end
  end

  // ***********************************
  // Checks
  // ***********************************
  property p_manual_ch;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    ev_r && wr_p0 && cmd_r.addr == ADDR_MANUAL && !swrst_nxt
      && !cmd_r.data[TEMP_BIT] |=> acq_o.ch == $past(cmd_r.data[CH_LO +: 2]);
  endproperty
  a_manual_ch: assert property (p_manual_ch)
    else $error("manual channel not taken");
  property p_result_pipe;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    ev_r |=> result_o == $past(acq_o);
  endproperty
  a_result_pipe: assert property (p_result_pipe)
    else $error("result does not follow acquisition");
  property p_pd_code;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    ev_r && !swrst_nxt && ovr_nxt == RANGE_PD |=> ##1 power_down_o;
  endproperty
  a_pd_code: assert property (p_pd_code)
    else $error("power-down code ignored");
  property p_temp_range;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    acq_o.temp |-> acq_o.range == RANGE_CFG;
  endproperty
  a_temp_range: assert property (p_temp_range)
    else $error("range applied to temperature slot");
  property p_restart;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    ev_r && wr_p0 && cmd_r.addr == ADDR_AUTO && !cmd_r.data[TEMP_BIT]
      && cmd_r.data[SEQ_RST_BIT] && mask_r == REG_RESET
      |=> acq_o.ch == CH_ZERO && mode_r == ACS_MODE_AUTO ##1 auto_mode_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("empty selection not channel 0");
  property p_zero_frame;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    ev_r && cmd_r == '0 |=> acq_o.range == RANGE_CFG
      && mode_r == $past(mode_r) && acq_o.temp == $past(temp_r);
  endproperty
  a_zero_frame: assert property (p_zero_frame)
    else $error("idle frame changed mode");
  property p_swrst;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    ev_r && swrst_nxt |=> dev_reset_o && aux_r == REG_RESET
      ##1 !dev_reset_o && ref_en_o == 1'b0;
  endproperty
  a_swrst: assert property (p_swrst)
    else $error("soft reset incomplete");
  property p_pin_dir;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    $changed(aux_r[PINFN_BIT])
      |=> alarm_or_sleep_pin_oe_o == !$past(aux_r[PINFN_BIT]);
  endproperty
  a_pin_dir: assert property (p_pin_dir)
    else $error("shared pin direction wrong");
  property p_auto_step;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    ev_r && mode_r == ACS_MODE_AUTO && cmd_r == '0 && !temp_r
      && mask_r[INC_CH0_BIT] && seq_r == 2'h3 |=> acq_o.ch == CH_ZERO;
  endproperty
  a_auto_step: assert property (p_auto_step)
    else $error("sequence did not wrap");

endmodule : acs_sequencer

// file: verification/acs_host_model.sv
// Serial host model: frames 16-bit words onto the sequencer link.
// Assumes the bench calls send() one frame at a time; sclk idles low.
`timescale 1ns/1ns
module acs_host_model
  import acs_pkg::*;
(
  // Serial link
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  localparam int HALF_NS = SCLK_NS / 2;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b1;
  end

  // ***********************************
  // Frame driver
  // ***********************************
  // Sixteen clocks MSB first, data set while sclk is low
  task automatic send(input logic [15:0] word);
    cs_n_o = 1'b0;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      din_o = word[i];
      #(HALF_NS) sclk_o = 1'b1;
      #(HALF_NS) sclk_o = 1'b0;
    end
    #(HALF_NS) cs_n_o = 1'b1;
    // Released line shows the inverse so a stale bit is never reused
    din_o = ~word[0];
  endtask : send
endmodule : acs_host_model

// file: verification/tb_top.sv
// Self-checking bench for the channel sequencer, one task a scenario.
// Assumes acs_host_model drives the link; the shared pin is resolved here.
`timescale 1ns/1ns
module tb_top;
  import acs_pkg::*;
  // ***********************************
  // Signals
  // ***********************************
  logic       sys_clk = 1'b0;
  logic       resetn, sclk, cs_n, din, pin_drv, alarm, pin_lvl;
  logic       pin_o, pin_oe, frame, auto_mode, pdown, dev_rst;
  logic       ref_en, temp_en, pin_fn, page, saw_rst, got_frame;
  logic [7:0] mask;
  acs_acq_s   acq, result, prev;
  int         n_errors, comparisons;

  always #(SYS_CLK_NS / 2) sys_clk = ~sys_clk;
  // Pin level from whoever has it enabled
  assign pin_lvl = pin_oe ? pin_o : pin_drv;

  acs_host_model i_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));

  acs_sequencer i_dut (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .sclk_i(sclk),
    .cs_n_i(cs_n), .din_i(din), .alarm_or_sleep_pin_i(pin_lvl),
    .alarm_or_sleep_pin_o(pin_o), .alarm_or_sleep_pin_oe_o(pin_oe),
    .alarm_i(alarm), .acq_o(acq), .result_o(result), .frame_o(frame),
    .auto_mode_o(auto_mode), .power_down_o(pdown), .dev_reset_o(dev_rst),
    .ref_en_o(ref_en), .temp_en_o(temp_en),
    .shared_pin_function_o(pin_fn), .page_o(page), .channel_mask_o(mask)
  );

  // ***********************************
  // Shared tasks
  // ***********************************
  task automatic check(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  function automatic logic [15:0] mk(input logic [6:0] a,
                                     input logic [7:0] d);
    acs_frame_s f;
    f.addr = a;
    f.wr   = 1'b1;
    f.data = d;
    return f;
  endfunction : mk

  // Every frame raises frame_o, so the wait ends before the 40-cycle bound
  task automatic go(input logic [15:0] w);
    int k;
    saw_rst = 1'b0;
    i_host.send(w);
    for (k = 0; k < 40 && frame !== 1'b1; k++) begin
      @(posedge sys_clk);
      #2;
      if (dev_rst === 1'b1) saw_rst = 1'b1;
    end
    got_frame = (frame === 1'b1);
    @(posedge sys_clk);
    #2;
  endtask : go

  task automatic acq_is(input logic t, input logic [1:0] ch,
                        input logic [2:0] rng);
    check("acq_o", {2'h0, acq}, {2'h0, t, ch, rng});
  endtask : acq_is

  // ***********************************
  // Scenarios
  // ***********************************
  task automatic t_init;
    check("channel_mask_o", mask, REG_RESET);
    check("page_o", 8'(page), 8'h00);
    check("ref_en_o", 8'(ref_en), 8'h00);
  endtask : t_init

  task automatic t_manual;
    logic [1:0] ch;
    logic [2:0] r;
    prev = '0;
    for (int i = 1; i < 7; i++) begin
      if (i == 4) continue;
      r  = i[2:0];
      ch = i[1:0];
      go(mk(ADDR_MANUAL, {1'b0, ch, 1'b0, r, 1'b0}));
      acq_is(1'b0, ch, r);
      check("result_o", {2'h0, result}, {2'h0, prev});
      prev = {1'b0, ch, r};
    end
    check("frame_o", 8'(got_frame), 8'h01);
    go(16'h0000);
    acq_is(1'b0, 2'h2, RANGE_CFG);
    check("result_o", {2'h0, result}, {2'h0, prev});
    check("auto_mode_o", 8'(auto_mode), 8'h00);
  endtask : t_manual

  task automatic t_power;
    go(mk(ADDR_MANUAL, 8'h0E));
    check("power_down_o", 8'(pdown), 8'h01);
    check("acq_ch", 8'(acq.ch), 8'h00);
    go(16'h0000);
    check("power_down_o", 8'(pdown), 8'h00);
  endtask : t_power

  task automatic t_temp;
    go(mk(ADDR_MANUAL, 8'h63));
    check("acq_temp", 8'(acq.temp), 8'h01);
    go(16'h0000);
    check("acq_temp", 8'(acq.temp), 8'h01);
    go(mk(ADDR_MANUAL, 8'h20));
    acq_is(1'b0, 2'h1, RANGE_CFG);
  endtask : t_temp

  task automatic t_aux;
    go(mk(ADDR_AUX, 8'h0E));
    check("ref_en_o", 8'(ref_en), 8'h01);
    check("temp_en_o", 8'(temp_en), 8'h01);
    check("pin_fn", 8'(pin_fn), 8'h01);
    check("pin_oe", 8'(pin_oe), 8'h00);
    pin_drv = 1'b1;
    repeat (6) @(posedge sys_clk);
    #2;
    check("power_down_o", 8'(pdown), 8'h01);
    pin_drv = 1'b0;
    go(mk(ADDR_AUX, 8'h04));
    check("temp_en_o", 8'(temp_en), 8'h00);
    check("pin_oe", 8'(pin_oe), 8'h01);
    alarm = 1'b1;
    repeat (3) @(posedge sys_clk);
    #2;
    check("pin_o", 8'(pin_o), 8'h01);
    alarm = 1'b0;
  endtask : t_aux

  task automatic t_auto;
    go(mk(ADDR_MASK, 8'h22));
    check("channel_mask_o", mask, 8'h22);
    go(mk(ADDR_AUTO, 8'h80));
    acq_is(1'b0, 2'h1, RANGE_CFG);
    check("auto_mode_o", 8'(auto_mode), 8'h01);
    go(16'h0000);
    acq_is(1'b0, 2'h3, RANGE_CFG);
    go(16'h0000);
    acq_is(1'b0, 2'h1, RANGE_CFG);
    go(mk(ADDR_AUTO, 8'h80));
    acq_is(1'b0, 2'h1, RANGE_CFG);
    go(16'h0000);
    acq_is(1'b0, 2'h3, RANGE_CFG);
    go(mk(ADDR_AUTO, 8'h01));
    check("acq_temp", 8'(acq.temp), 8'h01);
    go(mk(ADDR_AUTO, 8'h00));
    acq_is(1'b0, 2'h1, RANGE_CFG);
    go(mk(ADDR_AUTO, 8'h0A));
    acq_is(1'b0, 2'h3, 3'h5);
    go(16'h0000);
    acq_is(1'b0, 2'h1, RANGE_CFG);
  endtask : t_auto

  task automatic t_empty;
    go(mk(ADDR_MASK, 8'h00));
    go(mk(ADDR_AUTO, 8'h80));
    acq_is(1'b0, CH_ZERO, RANGE_CFG);
    go(16'h0000);
    acq_is(1'b0, CH_ZERO, RANGE_CFG);
    // Channels 0 and 3: wrap from the top back to channel 0
    go(mk(ADDR_MASK, 8'h82));
    go(mk(ADDR_AUTO, 8'h80));
    acq_is(1'b0, CH_ZERO, RANGE_CFG);
    go(16'h0000);
    acq_is(1'b0, 2'h3, RANGE_CFG);
    go(16'h0000);
    acq_is(1'b0, CH_ZERO, RANGE_CFG);
  endtask : t_empty

  task automatic t_page;
    go(mk(ADDR_PAGE, 8'h01));
    check("page_o", 8'(page), 8'h01);
    go(mk(ADDR_MANUAL, 8'h40));
    check("auto_mode_o", 8'(auto_mode), 8'h01);
    go(mk(ADDR_PAGE, 8'h00));
    check("page_o", 8'(page), 8'h00);
  endtask : t_page

  task automatic t_reset;
    go(mk(ADDR_AUX, 8'h06));
    go(mk(ADDR_MASK, 8'hAA));
    go(mk(ADDR_SWRST, 8'h01));
    check("dev_reset_o", 8'(saw_rst), 8'h01);
    check("ref_en_o", 8'(ref_en), 8'h00);
    check("channel_mask_o", mask, REG_RESET);
    check("auto_mode_o", 8'(auto_mode), 8'h00);
  endtask : t_reset

  // ***********************************
  // Main sequence and watchdog
  // ***********************************
  initial begin
    resetn  = 1'b0;
    pin_drv = 1'b0;
    alarm   = 1'b0;
    repeat (16) @(posedge sys_clk);
    #2 resetn = 1'b1;
    t_init;
    t_manual;
    t_power;
    t_temp;
    t_aux;
    t_auto;
    t_empty;
    t_page;
    t_reset;
    wrap_up;
  end

  // About forty frames of a few microseconds each fit well inside this
  initial begin
    #(1_000_000);
    n_errors++;
    wrap_up;
  end
endmodule : tb_top
